// file: hdl/cpu_interrupt_context_switch.v
// Purpose : reset, restart-load and maskable-interrupt context switch
// Assumes : core stalls while busy_o is high; memory answers reads in
//           the same cycle the read strobe is shown
// Notes   : owns the workspace pointer, counter load and status word
`timescale 1ns/1ps
`default_nettype none
`include "ctx_switch_defines.vh"

module cpu_interrupt_context_switch #(
  parameter ADDR_W = 16,
  parameter DATA_W = 16
) (
  input  wire              clock_i,
  input  wire              reset_n_i,
  input  wire              load_n_i,
  input  wire              irq_pending_n_i,
  input  wire [3:0]        irq_level_code_i,
  input  wire              instr_end_i,
  input  wire              branch_load_workspace_i,
  input  wire              extended_operation_i,
  input  wire              idle_i,
  input  wire              load_irq_mask_instr_i,
  input  wire [3:0]        mask_value_i,
  input  wire              return_workspace_i,
  input  wire [DATA_W-1:0] ret_wp_i,
  input  wire [DATA_W-1:0] ret_pc_i,
  input  wire [DATA_W-1:0] ret_status_i,
  input  wire              status_wr_i,
  input  wire [DATA_W-1:0] status_wdata_i,
  input  wire [DATA_W-1:0] core_pc_i,
  input  wire [DATA_W-1:0] mem_rdata_i,
  output wire [ADDR_W-1:0] mem_addr_o,
  output wire [DATA_W-1:0] mem_wdata_o,
  output wire              mem_rd_o,
  output wire              mem_wr_o,
  output wire [DATA_W-1:0] wp_o,
  output wire [DATA_W-1:0] pc_o,
  output wire              pc_load_o,
  output wire [DATA_W-1:0] status_word_o,
  output wire              instr_acquire_o,
  output wire              busy_o
);

  // ========================================================================
  // states and switch kinds
  localparam [4:0] S_RUN    = 5'h01;
  localparam [4:0] S_IDLE   = 5'h02;
  localparam [4:0] S_CMP    = 5'h04;
  localparam [4:0] S_WAIT   = 5'h08;
  localparam [4:0] S_SWITCH = 5'h10;

  localparam [2:0] K_RESET  = 3'h1;
  localparam [2:0] K_LOAD   = 3'h2;
  localparam [2:0] K_IRQ    = 3'h4;

  // ========================================================================
  // registers
  reg [4:0]        state_q;
  reg [2:0]        kind_q;
  reg [3:0]        step_q;
  reg              from_idle_q;
  reg              inhibit_q;
  reg              load_pend_q;
  reg              load_prev_q;
  reg [3:0]        level_q;
  reg [ADDR_W-1:0] vec_q;
  reg [DATA_W-1:0] new_wp_q;
  reg [DATA_W-1:0] new_pc_q;
  reg [DATA_W-1:0] temp_st_q;
  reg [DATA_W-1:0] wp_q;
  reg [DATA_W-1:0] pc_q;
  reg [DATA_W-1:0] status_q;
  reg              pc_load_q;
  reg              iaq_q;
  reg              busy_q;
  reg [ADDR_W-1:0] mem_addr_q;
  reg [DATA_W-1:0] mem_wdata_q;
  reg              mem_rd_q;
  reg              mem_wr_q;

  wire [3:0] mask_w;
  wire       cmp_ok;
  wire       vec_go;
  wire       load_edge;
  wire       irq_seen;

  assign mask_w    = status_q[`MASK_MSB:`MASK_LSB];
  // code not above mask is taken; code zero is never presented
  assign cmp_ok    = (state_q == S_CMP) && (irq_level_code_i <= mask_w);
  assign load_edge = load_prev_q && !load_n_i;
  assign irq_seen  = !irq_pending_n_i;

  // ========================================================================
  // compare-to-vector timing
  // the code lines are read again four cycles after the compare, so an
  // outside source that changes them in between gets the wrong vector
  pulse_delay #(
    .DEPTH (`CMP_TO_VECTOR_CYCLES)
  ) u_vec_delay (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .pulse_i   (cmp_ok),
    .pulse_o   (vec_go)
  );

  // ========================================================================
  // sequencer
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // reset releases straight into its own switch
      state_q     <= S_SWITCH;
      kind_q      <= K_RESET;
      step_q      <= `STEP_FIRST;
      from_idle_q <= 1'b0;
      inhibit_q   <= 1'b0;
      load_pend_q <= 1'b0;
      level_q     <= 4'h0;
      vec_q       <= `VEC_RESET;
      wp_q        <= 16'h0000;
      pc_q        <= 16'h0000;
      status_q    <= `STATUS_RESET;
      pc_load_q   <= 1'b0;
      iaq_q       <= 1'b0;
      busy_q      <= 1'b1;
    end else begin
      pc_load_q   <= 1'b0;
      iaq_q       <= 1'b0;

      case (state_q)
        S_RUN: begin
          if (return_workspace_i) begin
            // whole status comes back, mask included
            wp_q      <= ret_wp_i;
            pc_q      <= ret_pc_i;
            status_q  <= ret_status_i;
            pc_load_q <= 1'b1;
          end else if (load_irq_mask_instr_i) begin
            status_q[`MASK_MSB:`MASK_LSB] <= mask_value_i;
          end else if (status_wr_i) begin
            status_q <= status_wdata_i;
          end
          if (instr_end_i) begin
            inhibit_q <= branch_load_workspace_i || extended_operation_i;
            if (load_pend_q || load_edge) begin
              // not gated by mask or inhibit
              load_pend_q <= 1'b0;
              state_q     <= S_SWITCH;
              kind_q      <= K_LOAD;
              step_q      <= `STEP_ENTRY;
              vec_q       <= `VEC_LOAD;
              busy_q      <= 1'b1;
            end else if (irq_seen && !inhibit_q) begin
              // sampled here, compared next cycle
              state_q     <= S_CMP;
              from_idle_q <= 1'b0;
              busy_q      <= 1'b1;
            end
          end else if (idle_i) begin
            state_q <= S_IDLE;
          end
        end

        S_IDLE: begin
          if (load_pend_q || load_edge) begin
            // restart-load wakes the processor
            load_pend_q <= 1'b0;
            state_q     <= S_SWITCH;
            kind_q      <= K_LOAD;
            step_q      <= `STEP_ENTRY;
            vec_q       <= `VEC_LOAD;
            busy_q      <= 1'b1;
          end else if (irq_seen) begin
            state_q     <= S_CMP;
            from_idle_q <= 1'b1;
            busy_q      <= 1'b1;
          end
        end

        S_CMP: begin
          if (cmp_ok) begin
            state_q <= S_WAIT;
          end else begin
            // request refused by the mask: back where we came
            state_q <= from_idle_q ? S_IDLE : S_RUN;
            busy_q  <= 1'b0;
          end
        end

        S_WAIT: begin
          if (vec_go) begin
            // vector is level times four, plain binary code
            level_q <= irq_level_code_i;
            vec_q   <= {{(ADDR_W-4-`VEC_LEVEL_SHIFT){1'b0}}, irq_level_code_i,
                        {`VEC_LEVEL_SHIFT{1'b0}}};
            state_q <= S_SWITCH;
            kind_q  <= K_IRQ;
            step_q  <= `STEP_ENTRY;
          end
        end

        S_SWITCH: begin
          step_q <= step_q + 4'h1;
          if (step_q == `STEP_FIRST && kind_q == K_RESET && !load_n_i) begin
            // load already low as reset lets go
            load_pend_q <= 1'b1;
          end
          case (step_q)
            `STEP_RD_WP: begin
              if (kind_q == K_RESET) begin
                status_q <= `STATUS_RESET;
              end else if (kind_q == K_IRQ) begin
                status_q[`MASK_MSB:`MASK_LSB] <= level_q - 4'h1;
              end
            end
            `STEP_LAST: begin
              wp_q      <= new_wp_q;
              pc_q      <= new_pc_q;
              pc_load_q <= 1'b1;
              iaq_q     <= 1'b1;
              // first instruction of the new routine runs untested
              inhibit_q <= 1'b1;
              if (load_pend_q) begin
                // any switch, reset included, chains into the pending load
                load_pend_q <= 1'b0;
                kind_q      <= K_LOAD;
                step_q      <= `STEP_ENTRY;
                vec_q       <= `VEC_LOAD;
              end else begin
                state_q <= S_RUN;
                busy_q  <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end

        default: begin
          state_q <= S_RUN;
          busy_q  <= 1'b0;
        end
      endcase

      // an edge of the restart-load input is never lost while busy
      if (load_edge && state_q != S_RUN && state_q != S_IDLE) begin
        load_pend_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // restart-load edge detect
  // starts high so a low level at reset release counts as an edge
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_prev_q <= 1'b1;
    end else begin
      load_prev_q <= load_n_i;
    end
  end

  // ========================================================================
  // vector words and status copy of a switch
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      new_wp_q  <= 16'h0000;
      new_pc_q  <= 16'h0000;
      temp_st_q <= `STATUS_RESET;
    end else if (state_q == S_SWITCH) begin
      case (step_q)
        `STEP_RD_WP: begin
          // status copied before the sequencer clears or masks it
          new_wp_q  <= mem_rdata_i;
          temp_st_q <= status_q;
        end
        `STEP_RD_PC: begin
          new_pc_q <= mem_rdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // memory bus
  // one strobe per memory step; the setup steps between them keep the
  // bus quiet, so a slow memory always sees a gap between requests
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
    end else begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      if (state_q == S_SWITCH) begin
        // bus cycle for the step about to begin
        case (step_q)
          4'h2: begin
            mem_rd_q   <= 1'b1;
            mem_addr_q <= vec_q;
          end
          4'h4: begin
            mem_wr_q    <= 1'b1;
            mem_addr_q  <= new_wp_q + `SLOT_OLD_ST;
            mem_wdata_q <= temp_st_q;
          end
          4'h6: begin
            mem_wr_q    <= 1'b1;
            mem_addr_q  <= new_wp_q + `SLOT_OLD_PC;
            mem_wdata_q <= core_pc_i;
          end
          4'h8: begin
            mem_wr_q    <= 1'b1;
            mem_addr_q  <= new_wp_q + `SLOT_OLD_WP;
            mem_wdata_q <= wp_q;
          end
          4'hA: begin
            mem_rd_q   <= 1'b1;
            mem_addr_q <= vec_q + `VEC_PC_OFFSET;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ========================================================================
  // outputs
  assign mem_addr_o      = mem_addr_q;
  assign mem_wdata_o     = mem_wdata_q;
  assign mem_rd_o        = mem_rd_q;
  assign mem_wr_o        = mem_wr_q;
  assign wp_o            = wp_q;
  assign pc_o            = pc_q;
  assign pc_load_o       = pc_load_q;
  assign status_word_o   = status_q;
  assign instr_acquire_o = iaq_q;
  assign busy_o          = busy_q;

endmodule

`default_nettype wire

// file: hdl/ctx_switch_defines.vh
// Purpose : shared constants of the interrupt and restart sequencer
// Assumes : 16-bit words, byte addresses, workspace registers two bytes apart
// Notes   : included by bare name; definitions only
`ifndef CTX_SWITCH_DEFINES_VH
`define CTX_SWITCH_DEFINES_VH

// ==========================================================================
// vectors
`define VEC_RESET        16'h0000
`define VEC_LOAD         16'hFFFC
`define VEC_PC_OFFSET    16'h0002
`define VEC_LEVEL_SHIFT  2

// ==========================================================================
// save slots in the new workspace, byte offsets from the pointer
`define SLOT_OLD_WP      16'h001A
`define SLOT_OLD_PC      16'h001C
`define SLOT_OLD_ST      16'h001E

// ==========================================================================
// status word layout and reset value
`define MASK_MSB         3
`define MASK_LSB         0
`define STATUS_RESET     16'h0000

// ==========================================================================
// sequence steps; reset enters at the first, the others at the second
`define STEP_FIRST       4'h1
`define STEP_ENTRY       4'h2
`define STEP_RD_WP       4'h3
`define STEP_WR_ST       4'h5
`define STEP_WR_PC       4'h7
`define STEP_WR_WP       4'h9
`define STEP_RD_PC       4'hB
`define STEP_LAST        4'hC

// ==========================================================================
// timing, in clock cycles
`define SAMPLE_TO_VECTOR_CYCLES  5
`define CMP_TO_VECTOR_CYCLES     4
`define RESET_HOLD_MIN_CYCLES    3

`endif

// file: hdl/pulse_delay.v
// Purpose : delays a one-cycle pulse by a fixed number of clocks
// Assumes : single clock, asynchronous active-low reset
// Notes   : output taken straight from the last stage
`timescale 1ns/1ps
`default_nettype none

module pulse_delay #(
  parameter DEPTH = 4
) (
  input  wire clock_i,
  input  wire reset_n_i,
  input  wire pulse_i,
  output wire pulse_o
);

  reg  [DEPTH-1:0] stage_q;
  wire [DEPTH:0]   chain_w;

  // the input rides below the stages so one slice serves every depth
  assign chain_w = {stage_q, pulse_i};

  // ========================================================================
  // shift chain
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_q <= {DEPTH{1'b0}};
    end else begin
      stage_q <= chain_w[DEPTH-1:0];
    end
  end

  assign pulse_o = stage_q[DEPTH-1];

endmodule

`default_nettype wire

// file: sim/ctx_switch_monitor.sv
// Purpose: port checks of the interrupt and restart sequencer
// Assumes: 16-bit buses, one clock, reset active low
// Notes: bound to the design top from the testbench file
`timescale 1ns/1ps
`default_nettype none
module ctx_switch_monitor (
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        load_irq_mask_instr_i,
  input wire logic [3:0]  mask_value_i,
  input wire logic        return_workspace_i,
  input wire logic [15:0] ret_wp_i,
  input wire logic [15:0] ret_pc_i,
  input wire logic [15:0] ret_status_i,
  input wire logic [15:0] core_pc_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [15:0] wp_o,
  input wire logic [15:0] pc_o,
  input wire logic        pc_load_o,
  input wire logic [15:0] status_word_o,
  input wire logic        instr_acquire_o,
  input wire logic        busy_o
);
  // ==========================================================
  // sequence checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_reset_seq;
    $rose(reset_n_i) |-> ##1 !mem_rd_o ##1 (mem_rd_o && mem_addr_o == 16'h0000)
      ##8 (mem_rd_o && mem_addr_o == 16'h0002) ##2 (pc_load_o && instr_acquire_o);
  endproperty
  a_reset_seq: assert property (p_reset_seq)
    else $error("reset switch steps out of place");
  // every switch starts with an aligned pointer read
  property p_switch_seq;
    mem_rd_o && mem_addr_o[1:0] == 2'h0 |-> ##2 mem_wr_o ##2 mem_wr_o ##2 mem_wr_o
      ##2 mem_rd_o ##2 (pc_load_o && instr_acquire_o);
  endproperty
  a_switch_seq: assert property (p_switch_seq)
    else $error("switch steps out of place");
  property p_vec_pair;
    mem_rd_o && mem_addr_o[1:0] == 2'h0 |-> ##8 mem_addr_o == $past(mem_addr_o, 8) + 16'h0002;
  endproperty
  a_vec_pair: assert property (p_vec_pair)
    else $error("counter word not beside pointer word");
  property p_save_slot;
    mem_rd_o && mem_addr_o[1:0] == 2'h0 |-> ##2 mem_addr_o == $past(mem_rdata_i, 2) + 16'h001E;
  endproperty
  a_save_slot: assert property (p_save_slot)
    else $error("status not saved in slot fifteen");
  property p_save_data;
    mem_rd_o && mem_addr_o[1:0] == 2'h0 |-> ##2 mem_wdata_o == $past(status_word_o, 2)
      ##2 mem_wdata_o == $past(core_pc_i) ##2 mem_wdata_o == $past(wp_o, 6);
  endproperty
  a_save_data: assert property (p_save_data)
    else $error("saved context words wrong");
  property p_mask_level;
    mem_rd_o && mem_addr_o[1:0] == 2'h0 && mem_addr_o != 16'h0 && mem_addr_o < 16'h0040
      |=> status_word_o[3:0] == $past(mem_addr_o[5:2]) - 4'h1;
  endproperty
  a_mask_level: assert property (p_mask_level)
    else $error("mask not level minus one");
  property p_strobe_gap;
    mem_rd_o || mem_wr_o |=> !(mem_rd_o || mem_wr_o);
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("memory cycles not separated by setup");
  property p_mask_load;
    load_irq_mask_instr_i && !busy_o && !return_workspace_i
      |=> status_word_o[3:0] == $past(mask_value_i);
  endproperty
  a_mask_load: assert property (p_mask_load)
    else $error("mask load lost");
  property p_return;
    return_workspace_i && !busy_o |=> wp_o == $past(ret_wp_i) && pc_o == $past(ret_pc_i)
      && status_word_o == $past(ret_status_i);
  endproperty
  a_return: assert property (p_return)
    else $error("return did not restore context");
endmodule
`default_nettype wire

// file: sim/ctx_mem_model.sv
// Purpose: system memory holding the vector words
// Assumes: reads answered in the cycle the strobe is shown
// Notes: writes are accepted and dropped
`timescale 1ns/1ps
`default_nettype none
module ctx_mem_model (
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o
);
  // ==========================================================
  // vector contents
  logic [15:0] word;
  // pointer at the vector, counter two above
  // pairs at 0000, FFFC and level times four
  assign word = addr_i[1] ? 16'h2000 + addr_i - 16'h0002 : 16'h1000 + addr_i;
  // unselected bus shows the inverse so a late sample cannot pass
  assign rdata_o = rd_i ? word : ~word;
endmodule
`default_nettype wire

// file: sim/cpu_interrupt_context_switch_test.sv
// Purpose: self-checking bench of the interrupt and restart sequencer
// Assumes: core stalls while busy, so boundaries come only when idle
// Notes: ordinary interrupt cases run from a row table
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_context_switch_test;
  logic        clock_i, reset_n_i, load_n_i, irq_pending_n_i, instr_end_i;
  logic        branch_load_workspace_i, extended_operation_i, idle_i;
  logic        load_irq_mask_instr_i, return_workspace_i, status_wr_i;
  logic        mem_rd_o, mem_wr_o, pc_load_o, instr_acquire_o, busy_o;
  logic [3:0]  irq_level_code_i, mask_value_i;
  logic [15:0] ret_wp_i, ret_pc_i, ret_status_i, status_wdata_i, core_pc_i;
  logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, wp_o, pc_o, status_word_o;
  logic [15:0] exp_pc;
  logic [11:0] rows [0:18];
  int          n_fail, cmp_count, cyc, i, k;

  cpu_interrupt_context_switch DUT (.*);
  ctx_mem_model mem (.addr_i(mem_addr_o), .rd_i(mem_rd_o), .rdata_o(mem_rdata_i));

  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      final_report;
    end
  end

  // ==========================================================
  // tasks
  task tick;
    @(posedge clock_i);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task settle;
    repeat (3) tick;
    k = 0;
    while (busy_o !== 1'b0 && k < 200) begin
      tick;
      k++;
    end
    if (k == 200) chk(16'h0000, 16'h0001);
  endtask
  task boundary(input logic bl, input logic xo);
    branch_load_workspace_i = bl;
    extended_operation_i = xo;
    instr_end_i = 1'b1;
    tick;
    instr_end_i = 1'b0;
    branch_load_workspace_i = 1'b0;
    extended_operation_i = 1'b0;
    settle;
  endtask
  task setmask(input logic [3:0] m);
    mask_value_i = m;
    load_irq_mask_instr_i = 1'b1;
    tick;
    load_irq_mask_instr_i = 1'b0;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {clock_i, reset_n_i, instr_end_i, idle_i, status_wr_i} = 5'h00;
    {branch_load_workspace_i, extended_operation_i, return_workspace_i} = 3'h0;
    {load_n_i, irq_pending_n_i, load_irq_mask_instr_i} = 3'h6;
    {irq_level_code_i, mask_value_i} = 8'h11;
    {ret_wp_i, ret_pc_i, ret_status_i} = 48'h0;
    {status_wdata_i, core_pc_i} = 32'h0000_0ABC;
    for (i = 0; i < 15; i++) rows[i] = {4'hF, 4'(i + 1), 4'h1};
    rows[15] = 12'h010;
    rows[16] = 12'h780;
    rows[17] = 12'h881;
    rows[18] = 12'hEF0;
    repeat (16) tick;
    chk({15'h0, busy_o}, 16'h0001);
    reset_n_i = 1'b1;
    settle;
    exp_pc = 16'h2000;
    chk(pc_o, exp_pc);
    chk(wp_o, 16'h1000);
    chk(status_word_o, 16'h0000);
    $display("end of reset test");
    for (i = 0; i < 19; i++) begin
      // a clean boundary first clears the hold left by a switch
      boundary(1'b0, 1'b0);
      setmask(rows[i][11:8]);
      irq_level_code_i = rows[i][7:4];
      irq_pending_n_i = 1'b0;
      boundary(1'b0, 1'b0);
      irq_pending_n_i = 1'b1;
      if (rows[i][0]) exp_pc = 16'h2000 + {10'h0, rows[i][7:4], 2'b00};
      chk(pc_o, exp_pc);
      chk({12'h0, status_word_o[3:0]}, rows[i][0] ? {12'h0, rows[i][7:4] - 4'h1}
        : {12'h0, rows[i][11:8]});
    end
    $display("end of level table");
    setmask(4'h0);
    idle_i = 1'b1;
    tick;
    idle_i = 1'b0;
    repeat (4) tick;
    load_n_i = 1'b0;
    settle;
    load_n_i = 1'b1;
    chk(pc_o, 16'h1FFC);
    chk(wp_o, 16'h0FFC);
    chk({12'h0, status_word_o[3:0]}, 16'h0000);
    $display("end of idle load test");
    boundary(1'b0, 1'b0);
    setmask(4'hF);
    irq_level_code_i = 4'h1;
    irq_pending_n_i = 1'b0;
    load_n_i = 1'b0;
    boundary(1'b0, 1'b0);
    load_n_i = 1'b1;
    chk(pc_o, 16'h1FFC);
    boundary(1'b0, 1'b0);
    chk(pc_o, 16'h1FFC);
    boundary(1'b0, 1'b0);
    chk(pc_o, 16'h2004);
    irq_pending_n_i = 1'b1;
    $display("end of order test");
    boundary(1'b0, 1'b0);
    setmask(4'hF);
    irq_level_code_i = 4'h5;
    irq_pending_n_i = 1'b0;
    instr_end_i = 1'b1;
    tick;
    instr_end_i = 1'b0;
    tick;
    // code moves after the compare; the later read picks the vector
    irq_level_code_i = 4'h6;
    settle;
    irq_pending_n_i = 1'b1;
    exp_pc = 16'h2018;
    chk(pc_o, exp_pc);
    $display("end of late code test");
    for (i = 0; i < 2; i++) begin
      boundary(1'b0, 1'b0);
      setmask(4'hF);
      boundary(i == 0, i == 1);
      irq_level_code_i = 4'(3 + i);
      irq_pending_n_i = 1'b0;
      boundary(1'b0, 1'b0);
      chk(pc_o, exp_pc);
      boundary(1'b0, 1'b0);
      irq_pending_n_i = 1'b1;
      exp_pc = 16'h2000 + {10'h0, 4'(3 + i), 2'b00};
      chk(pc_o, exp_pc);
    end
    $display("end of hold test");
    {ret_wp_i, ret_pc_i, ret_status_i} = {16'h0120, 16'h0456, 16'hC007};
    return_workspace_i = 1'b1;
    tick;
    return_workspace_i = 1'b0;
    tick;
    chk(wp_o, 16'h0120);
    chk(pc_o, 16'h0456);
    chk(status_word_o, 16'hC007);
    $display("end of return test");
    status_wdata_i = 16'h5A0F;
    status_wr_i = 1'b1;
    tick;
    status_wr_i = 1'b0;
    chk(status_word_o, 16'h5A0F);
    idle_i = 1'b1;
    tick;
    idle_i = 1'b0;
    irq_level_code_i = 4'h2;
    irq_pending_n_i = 1'b0;
    settle;
    irq_pending_n_i = 1'b1;
    chk(pc_o, 16'h2008);
    $display("end of idle wake test");
    reset_n_i = 1'b0;
    load_n_i = 1'b0;
    repeat (3) tick;
    reset_n_i = 1'b1;
    settle;
    load_n_i = 1'b1;
    chk(pc_o, 16'h1FFC);
    chk(wp_o, 16'h0FFC);
    $display("end of reset load test");
    final_report;
  end
endmodule

bind cpu_interrupt_context_switch ctx_switch_monitor mon (.*);
`default_nettype wire
